// [rtl/pid_alarm_pkg.sv]
package pid_alarm_pkg;

	// Datapath widths.
	localparam int PV_W   = 16;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int SEL_W  = 8;

	// Register byte offsets.
	localparam logic [7:0] OFF_THRESHOLD  = 8'h00;
	localparam logic [7:0] OFF_POLARITY   = 8'h04;
	localparam logic [7:0] OFF_FUNC_SEL   = 8'h08;
	localparam logic [7:0] OFF_FLAGS      = 8'h0C;
	localparam logic [7:0] OFF_ERROR      = 8'h10;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
	localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h18;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h1C;

	// Field positions.
	localparam int POL_BIT      = 0;
	localparam int SEL_ONE_LSB  = 0;
	localparam int SEL_TWO_LSB  = 8;
	localparam int SEL_ALM_LSB  = 16;
	localparam int EVT_DEV_BIT  = 0;
	localparam int EVT_ALM_BIT  = 1;
	localparam int EVT_W        = 2;

	// Output function selection codes.
	localparam logic [7:0] FUNC_DEVIATION = 8'h04;
	localparam logic [7:0] FUNC_ALARM     = 8'h05;

	// Reset values.
	localparam logic [15:0] RST_THRESHOLD  = 16'h0000;
	localparam logic        RST_NORM_CLOSE = 1'b1;
	localparam logic [7:0]  RST_SEL_RELAY  = 8'h00;
	localparam logic [7:0]  RST_SEL_ALARM  = FUNC_ALARM;
	localparam logic [1:0]  RST_EVT        = 2'h0;
	localparam logic [31:0] RD_ZERO        = 32'h0000_0000;

	typedef struct packed {
		logic [15:0] threshold;
		logic        normally_closed;
		logic [7:0]  sel_alarm;
		logic [7:0]  sel_relay_two;
		logic [7:0]  sel_relay_one;
	} out_cfg_t;

	typedef struct packed {
		logic alarm;
		logic deviation;
	} flags_t;

endpackage

// [rtl/pid_deviation_compare.sv]
`timescale 1ns/1ns
module pid_deviation_compare (
	// Clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_sys_rst,
	// Loop values and threshold
	input  wire logic [15:0] i_setpoint,
	input  wire logic [15:0] i_process_value,
	input  wire logic [15:0] i_threshold,
	// Results
	output logic      [15:0] o_error_mag,
	output logic             o_deviation_flag
);

	function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
		abs_diff = (a >= b) ? 16'(a - b) : 16'(b - a);
	endfunction

	logic [15:0] next_error_mag;

	assign next_error_mag = abs_diff(i_setpoint, i_process_value);

	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_error_mag <= 16'h0000;
		else
			o_error_mag <= next_error_mag;
	end

	// threshold compare
	// An exact match keeps the old state so a steady error sitting on the threshold cannot chatter.
	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_deviation_flag <= 1'b0;
		else if (next_error_mag > i_threshold)
			o_deviation_flag <= 1'b1;
		else if (next_error_mag < i_threshold)
			o_deviation_flag <= 1'b0;
	end

	error_magnitude_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		1'b1 |=> o_error_mag == abs_diff($past(i_setpoint), $past(i_process_value)))
		else $error("error magnitude is not the absolute difference");

	deviation_set_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(abs_diff(i_setpoint, i_process_value) > i_threshold) |=> o_deviation_flag)
		else $error("deviation flag not set above threshold");

	deviation_clear_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(abs_diff(i_setpoint, i_process_value) < i_threshold) |=> !o_deviation_flag)
		else $error("deviation flag not cleared below threshold");

	deviation_hold_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(abs_diff(i_setpoint, i_process_value) == i_threshold) |=> $stable(o_deviation_flag))
		else $error("deviation flag moved at equal threshold");

endmodule

// [rtl/pid_deviation_alarm_outputs.sv]
`timescale 1ns/1ns
module pid_deviation_alarm_outputs (
	// Clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_sys_rst,
	// Register port
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [31:0] i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic      [31:0] o_reg_rdata,
	// PID loop values
	input  wire logic [15:0] i_setpoint,
	input  wire logic [15:0] i_process_value,
	// Drive fault state
	input  wire logic        i_fault_event,
	input  wire logic        i_trip_mode,
	input  wire logic        i_fault_clear,
	// Logic flags
	output logic             o_pid_deviation_flag,
	output logic             o_fault_alarm_flag,
	// Relay coils and alarm relay contacts
	output logic             o_relay_out_one,
	output logic             o_relay_out_two,
	output logic             o_alarm_relay_contact_one_closed,
	output logic             o_alarm_relay_contact_two_closed,
	// Interrupt
	output logic             o_irq
);

	pid_alarm_pkg::out_cfg_t cfg;
	pid_alarm_pkg::flags_t   flags;
	pid_alarm_pkg::flags_t   prev_flags;

	logic [15:0] error_mag;
	logic        deviation_flag;
	logic        fault_latched;
	logic        next_fault_latched;
	logic        alarm_relay_active;
	logic [1:0]  irq_status;
	logic [1:0]  irq_enable;
	logic [1:0]  irq_set;
	logic [1:0]  irq_clear;

	// Picks the flag that a terminal carries for its function code; unknown codes leave it idle.
	function automatic logic term_level(input logic [7:0] sel, input pid_alarm_pkg::flags_t f);
		if (sel == pid_alarm_pkg::FUNC_DEVIATION)
			term_level = f.deviation;
		else if (sel == pid_alarm_pkg::FUNC_ALARM)
			term_level = f.alarm;
		else
			term_level = 1'b0;
	endfunction

	function automatic logic wr_hit(input logic [7:0] off);
		wr_hit = i_reg_wr && (i_reg_addr == off);
	endfunction

	pid_deviation_compare u_compare (
		.i_core_clk       (i_core_clk),
		.i_sys_rst        (i_sys_rst),
		.i_setpoint       (i_setpoint),
		.i_process_value  (i_process_value),
		.i_threshold      (cfg.threshold),
		.o_error_mag      (error_mag),
		.o_deviation_flag (deviation_flag)
	);

	// Configuration registers.
	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			cfg.threshold <= pid_alarm_pkg::RST_THRESHOLD;
		else if (wr_hit(pid_alarm_pkg::OFF_THRESHOLD))
			cfg.threshold <= i_reg_wdata[15:0];
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			cfg.normally_closed <= pid_alarm_pkg::RST_NORM_CLOSE;
		else if (wr_hit(pid_alarm_pkg::OFF_POLARITY))
			cfg.normally_closed <= i_reg_wdata[pid_alarm_pkg::POL_BIT];
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			cfg.sel_relay_one <= pid_alarm_pkg::RST_SEL_RELAY;
			cfg.sel_relay_two <= pid_alarm_pkg::RST_SEL_RELAY;
			cfg.sel_alarm     <= pid_alarm_pkg::RST_SEL_ALARM;
		end
		else if (wr_hit(pid_alarm_pkg::OFF_FUNC_SEL))
		begin
			cfg.sel_relay_one <= i_reg_wdata[pid_alarm_pkg::SEL_ONE_LSB +: 8];
			cfg.sel_relay_two <= i_reg_wdata[pid_alarm_pkg::SEL_TWO_LSB +: 8];
			cfg.sel_alarm     <= i_reg_wdata[pid_alarm_pkg::SEL_ALM_LSB +: 8];
		end
	end

	// fault latch
	// A fault arriving in the same cycle as a clear wins, so no fault is lost.
	assign next_fault_latched = i_fault_event | (fault_latched & ~i_fault_clear);

	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			fault_latched <= 1'b0;
		else
			fault_latched <= next_fault_latched;
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_fault_alarm_flag <= 1'b0;
		else
			o_fault_alarm_flag <= next_fault_latched & i_trip_mode;
	end

	assign o_pid_deviation_flag = deviation_flag;
	assign flags.deviation      = deviation_flag;
	assign flags.alarm          = o_fault_alarm_flag;

	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_relay_out_one <= 1'b0;
			o_relay_out_two <= 1'b0;
		end
		else
		begin
			o_relay_out_one <= term_level(cfg.sel_relay_one, flags);
			o_relay_out_two <= term_level(cfg.sel_relay_two, flags);
		end
	end

	assign alarm_relay_active = term_level(cfg.sel_alarm, flags);

	// contact polarity
	// Under reset the relay sits in its active position, the same state it shows with power removed.
	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_alarm_relay_contact_one_closed <= 1'b0;
			o_alarm_relay_contact_two_closed <= 1'b1;
		end
		else
		begin
			o_alarm_relay_contact_one_closed <= cfg.normally_closed ? ~alarm_relay_active : alarm_relay_active;
			o_alarm_relay_contact_two_closed <= cfg.normally_closed ? alarm_relay_active : ~alarm_relay_active;
		end
	end

	// Interrupt events are rising edges of the two flags.
	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			prev_flags <= '0;
		else
			prev_flags <= flags;
	end

	assign irq_set[pid_alarm_pkg::EVT_DEV_BIT] = flags.deviation & ~prev_flags.deviation;
	assign irq_set[pid_alarm_pkg::EVT_ALM_BIT] = flags.alarm & ~prev_flags.alarm;
	assign irq_clear = wr_hit(pid_alarm_pkg::OFF_IRQ_CLEAR) ? i_reg_wdata[1:0] : 2'h0;

	// Setting beats clearing, so an edge in the clear cycle still raises the bit.
	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			irq_status <= pid_alarm_pkg::RST_EVT;
		else
			irq_status <= (irq_status & ~irq_clear) | irq_set;
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			irq_enable <= pid_alarm_pkg::RST_EVT;
		else if (wr_hit(pid_alarm_pkg::OFF_IRQ_ENABLE))
			irq_enable <= i_reg_wdata[1:0];
	end

	assign o_irq = |(irq_status & irq_enable);

	// Read data stand for the one cycle after the strobe and are zero otherwise.
	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_reg_rdata <= pid_alarm_pkg::RD_ZERO;
		else if (!i_reg_rd)
			o_reg_rdata <= pid_alarm_pkg::RD_ZERO;
		else
		begin
			unique case (i_reg_addr)
				pid_alarm_pkg::OFF_THRESHOLD:  o_reg_rdata <= {16'h0000, cfg.threshold};
				pid_alarm_pkg::OFF_POLARITY:   o_reg_rdata <= {31'h0000_0000, cfg.normally_closed};
				pid_alarm_pkg::OFF_FUNC_SEL:
					o_reg_rdata <= {8'h00, cfg.sel_alarm, cfg.sel_relay_two, cfg.sel_relay_one};
				pid_alarm_pkg::OFF_FLAGS:      o_reg_rdata <= {30'h0000_0000, flags.alarm, flags.deviation};
				pid_alarm_pkg::OFF_ERROR:      o_reg_rdata <= {16'h0000, error_mag};
				pid_alarm_pkg::OFF_IRQ_STATUS: o_reg_rdata <= {30'h0000_0000, irq_status};
				pid_alarm_pkg::OFF_IRQ_ENABLE: o_reg_rdata <= {30'h0000_0000, irq_enable};
				default:                       o_reg_rdata <= pid_alarm_pkg::RD_ZERO;
			endcase
		end
	end

	alarm_hold_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(fault_latched && i_trip_mode && !i_fault_clear) |=> o_fault_alarm_flag)
		else $error("alarm flag not held during trip");

	alarm_release_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_fault_clear && !i_fault_event) |=> !o_fault_alarm_flag [*1] ##1 1'b1)
		else $error("alarm flag stayed on after clear");

	deviation_route_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(cfg.sel_relay_one == pid_alarm_pkg::FUNC_DEVIATION) |=> o_relay_out_one == $past(flags.deviation))
		else $error("relay one does not follow deviation flag");

	alarm_route_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(cfg.sel_relay_two == pid_alarm_pkg::FUNC_ALARM) |=> o_relay_out_two == $past(flags.alarm))
		else $error("relay two does not follow alarm flag");

	alarm_relay_route_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(cfg.sel_alarm == pid_alarm_pkg::FUNC_ALARM && cfg.normally_closed) |=>
			o_alarm_relay_contact_one_closed == !$past(flags.alarm))
		else $error("alarm relay does not follow alarm flag");

	alarm_default_a: assert property (@(posedge i_core_clk)
		$fell(i_sys_rst) |-> (cfg.sel_alarm == pid_alarm_pkg::FUNC_ALARM) && cfg.normally_closed)
		else $error("alarm relay default function wrong");

	contact_sense_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(!cfg.normally_closed && alarm_relay_active) |=>
			o_alarm_relay_contact_one_closed && !o_alarm_relay_contact_two_closed)
		else $error("open-sense contacts wrong while active");

	contact_pair_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		o_alarm_relay_contact_one_closed != o_alarm_relay_contact_two_closed)
		else $error("alarm relay contacts not complementary");

	irq_set_wins_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(irq_set[pid_alarm_pkg::EVT_ALM_BIT]) |=> irq_status[pid_alarm_pkg::EVT_ALM_BIT])
		else $error("alarm event lost from interrupt status");

	rdata_idle_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		!i_reg_rd |=> o_reg_rdata == pid_alarm_pkg::RD_ZERO)
		else $error("read data not zero outside a read");

	threshold_read_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_reg_rd && i_reg_addr == pid_alarm_pkg::OFF_THRESHOLD) |=>
			o_reg_rdata == {16'h0000, $past(cfg.threshold)})
		else $error("threshold read back wrong");

	flags_read_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_reg_rd && i_reg_addr == pid_alarm_pkg::OFF_FLAGS) |=>
			o_reg_rdata == {30'h0000_0000, $past(flags.alarm), $past(flags.deviation)})
		else $error("flags read back wrong");

	clear_reads_zero_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_reg_rd && i_reg_addr == pid_alarm_pkg::OFF_IRQ_CLEAR) |=> o_reg_rdata == pid_alarm_pkg::RD_ZERO)
		else $error("clear register did not read zero");

	threshold_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		wr_hit(pid_alarm_pkg::OFF_THRESHOLD) |=>
			cfg.threshold == $past(i_reg_wdata[15:0]))
		else $error("threshold write not taken");

	polarity_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		wr_hit(pid_alarm_pkg::OFF_POLARITY) |=>
			cfg.normally_closed == $past(i_reg_wdata[pid_alarm_pkg::POL_BIT]))
		else $error("polarity write not taken");

	select_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		wr_hit(pid_alarm_pkg::OFF_FUNC_SEL) |=>
			cfg.sel_alarm == $past(i_reg_wdata[pid_alarm_pkg::SEL_ALM_LSB +: 8]))
		else $error("alarm relay function write not taken");

	fault_latch_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_fault_event |=> fault_latched)
		else $error("fault event not latched");

	alarm_needs_trip_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		!i_trip_mode |=> !o_fault_alarm_flag)
		else $error("alarm flag on outside trip mode");

	relay_one_alarm_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(cfg.sel_relay_one == pid_alarm_pkg::FUNC_ALARM) |=> o_relay_out_one == $past(flags.alarm))
		else $error("relay one does not follow alarm flag");

	relay_two_deviation_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(cfg.sel_relay_two == pid_alarm_pkg::FUNC_DEVIATION) |=> o_relay_out_two == $past(flags.deviation))
		else $error("relay two does not follow deviation flag");

	unknown_code_idle_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(cfg.sel_relay_one != pid_alarm_pkg::FUNC_DEVIATION && cfg.sel_relay_one != pid_alarm_pkg::FUNC_ALARM)
			|=> !o_relay_out_one)
		else $error("relay one active under an unknown code");

	alarm_relay_deviation_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(cfg.sel_alarm == pid_alarm_pkg::FUNC_DEVIATION && cfg.normally_closed) |=>
			o_alarm_relay_contact_one_closed == !$past(flags.deviation))
		else $error("alarm relay does not follow deviation flag");

	irq_clear_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(wr_hit(pid_alarm_pkg::OFF_IRQ_CLEAR) && i_reg_wdata[pid_alarm_pkg::EVT_ALM_BIT]
			&& !irq_set[pid_alarm_pkg::EVT_ALM_BIT]) |=> !irq_status[pid_alarm_pkg::EVT_ALM_BIT])
		else $error("alarm interrupt status not cleared");

	irq_sticky_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(irq_status[pid_alarm_pkg::EVT_ALM_BIT] && !wr_hit(pid_alarm_pkg::OFF_IRQ_CLEAR)) |=>
			irq_status[pid_alarm_pkg::EVT_ALM_BIT])
		else $error("alarm interrupt status dropped without a clear");

	deviation_event_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		$rose(flags.deviation) |=> irq_status[pid_alarm_pkg::EVT_DEV_BIT])
		else $error("deviation event lost from interrupt status");

	contact_normal_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(cfg.normally_closed && !alarm_relay_active) |=>
			o_alarm_relay_contact_one_closed && !o_alarm_relay_contact_two_closed)
		else $error("closed-sense contacts wrong while idle");

endmodule

// [bench/relay_load_model.sv]
`timescale 1ns/1ns
module relay_load_model (
	// Alarm relay contacts
	input  wire logic i_contact_one_closed,
	input  wire logic i_contact_two_closed,
	// Lamp wired through common and contact two
	output logic      o_trip_lamp
);
	// Both contacts closed at once would short the supply, so the lamp stays dark then.
	assign o_trip_lamp = i_contact_two_closed & ~i_contact_one_closed;
endmodule

// [bench/pid_deviation_alarm_outputs_bench.sv]
`timescale 1ns/1ns
module pid_deviation_alarm_outputs_bench;
	logic        core_clk;
	logic        sys_rst;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic [15:0] setpoint;
	logic [15:0] process_value;
	logic        fault_event;
	logic        trip_mode;
	logic        fault_clear;
	logic        dev_flag;
	logic        alm_flag;
	logic        relay_one;
	logic        relay_two;
	logic        cont_one;
	logic        cont_two;
	logic        irq;
	logic        lamp;
	logic [31:0] rv;
	int          n_fail;
	int          samples_checked;

	pid_deviation_alarm_outputs i_dut (
		.i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
		.i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .i_setpoint(setpoint),
		.i_process_value(process_value), .i_fault_event(fault_event), .i_trip_mode(trip_mode),
		.i_fault_clear(fault_clear), .o_pid_deviation_flag(dev_flag), .o_fault_alarm_flag(alm_flag),
		.o_relay_out_one(relay_one), .o_relay_out_two(relay_two),
		.o_alarm_relay_contact_one_closed(cont_one), .o_alarm_relay_contact_two_closed(cont_two),
		.o_irq(irq)
	);

	relay_load_model i_load (
		.i_contact_one_closed(cont_one),
		.i_contact_two_closed(cont_two),
		.o_trip_lamp(lamp)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		#1;
		rv = reg_rdata;
	endtask

	// Relays trail the loop inputs by two edges, so three edges cover every path.
	task automatic settle();
		repeat (3) @(posedge core_clk);
		#1;
	endtask

	task automatic t_reset();
		rd(pid_alarm_pkg::OFF_THRESHOLD);  chk(rv, 32'h0000_0000, "threshold reset");
		rd(pid_alarm_pkg::OFF_POLARITY);   chk(rv, 32'h0000_0001, "polarity reset");
		rd(pid_alarm_pkg::OFF_FUNC_SEL);   chk(rv, 32'h0005_0000, "function select reset");
		rd(pid_alarm_pkg::OFF_IRQ_ENABLE); chk(rv, 32'h0000_0000, "irq enable reset");
		rd(pid_alarm_pkg::OFF_IRQ_CLEAR);  chk(rv, 32'h0000_0000, "irq clear reads zero");
		rd(8'h20);                         chk(rv, 32'h0000_0000, "unmapped read");
		chk(cont_one, 1'b1, "contact one at run");
		chk(cont_two, 1'b0, "contact two at run");
		$display("reset test done");
	endtask

	task automatic t_deviation();
		wr(pid_alarm_pkg::OFF_THRESHOLD, 32'h0000_0064);
		wr(pid_alarm_pkg::OFF_FUNC_SEL, 32'h0005_0004);
		@(posedge core_clk);
		setpoint      <= 16'h03E8;
		process_value <= 16'h04B0;
		settle();
		chk(dev_flag, 1'b1, "deviation above threshold");
		chk(relay_one, 1'b1, "relay one carries deviation");
		chk(irq, 1'b0, "deviation event masked");
		rd(pid_alarm_pkg::OFF_ERROR); chk(rv, 32'h0000_00C8, "error magnitude");
		@(posedge core_clk);
		process_value <= 16'h044C;
		settle();
		chk(dev_flag, 1'b1, "equal keeps flag");
		@(posedge core_clk);
		process_value <= 16'h041A;
		settle();
		chk(dev_flag, 1'b0, "deviation below threshold");
		chk(relay_one, 1'b0, "relay one follows flag");
		@(posedge core_clk);
		process_value <= 16'h044C;
		settle();
		chk(dev_flag, 1'b0, "equal keeps flag low");
		@(posedge core_clk);
		setpoint      <= 16'h04B0;
		process_value <= 16'h03E8;
		settle();
		chk(dev_flag, 1'b1, "negative difference");
		rd(pid_alarm_pkg::OFF_IRQ_STATUS); chk(rv, 32'h0000_0001, "deviation event status");
		@(posedge core_clk);
		setpoint <= 16'h03E8;
		settle();
		$display("deviation test done");
	endtask

	task automatic t_alarm();
		wr(pid_alarm_pkg::OFF_IRQ_CLEAR, 32'h0000_0003);
		wr(pid_alarm_pkg::OFF_IRQ_ENABLE, 32'h0000_0002);
		wr(pid_alarm_pkg::OFF_FUNC_SEL, 32'h0005_0500);
		@(posedge core_clk);
		fault_event <= 1'b1;
		@(posedge core_clk);
		fault_event <= 1'b0;
		settle();
		chk(alm_flag, 1'b0, "no alarm outside trip");
		@(posedge core_clk);
		trip_mode <= 1'b1;
		settle();
		chk(alm_flag, 1'b1, "alarm in trip");
		chk(relay_two, 1'b1, "relay two carries alarm");
		chk({cont_one, cont_two, lamp}, 3'b011, "contacts at trip");
		chk(irq, 1'b1, "alarm interrupt");
		rd(pid_alarm_pkg::OFF_IRQ_STATUS); chk(rv, 32'h0000_0002, "alarm event status");
		wr(pid_alarm_pkg::OFF_IRQ_CLEAR, 32'h0000_0002);
		#1;
		chk(irq, 1'b0, "interrupt cleared");
		@(posedge core_clk);
		fault_clear <= 1'b1;
		@(posedge core_clk);
		fault_clear <= 1'b0;
		settle();
		chk(alm_flag, 1'b0, "alarm dropped by clear");
		chk(relay_two, 1'b0, "relay two off after clear");
		chk({cont_one, cont_two, lamp}, 3'b100, "contacts back to run");
		$display("alarm test done");
	endtask

	task automatic t_polarity();
		wr(pid_alarm_pkg::OFF_POLARITY, 32'h0000_0000);
		settle();
		chk({cont_one, cont_two}, 2'b01, "inverted contacts at run");
		@(posedge core_clk);
		fault_event <= 1'b1;
		@(posedge core_clk);
		fault_event <= 1'b0;
		settle();
		chk({cont_one, cont_two}, 2'b10, "inverted contacts at trip");
		@(posedge core_clk);
		fault_clear <= 1'b1;
		@(posedge core_clk);
		fault_clear <= 1'b0;
		wr(pid_alarm_pkg::OFF_POLARITY, 32'h0000_0001);
		$display("polarity test done");
	endtask

	task automatic t_routing();
		wr(pid_alarm_pkg::OFF_FUNC_SEL, 32'h0004_0405);
		@(posedge core_clk);
		process_value <= 16'h0320;
		settle();
		chk(relay_two, 1'b1, "relay two carries deviation");
		chk({cont_one, cont_two, lamp}, 3'b011, "alarm relay carries deviation");
		rd(pid_alarm_pkg::OFF_FLAGS); chk(rv, 32'h0000_0001, "flags register");
		@(posedge core_clk);
		fault_event <= 1'b1;
		@(posedge core_clk);
		fault_event <= 1'b0;
		settle();
		chk(relay_one, 1'b1, "relay one carries alarm");
		rd(pid_alarm_pkg::OFF_FLAGS); chk(rv, 32'h0000_0003, "flags register both");
		@(posedge core_clk);
		fault_clear   <= 1'b1;
		process_value <= 16'h03E8;
		@(posedge core_clk);
		fault_clear <= 1'b0;
		settle();
		chk({relay_one, relay_two}, 2'b00, "relays idle after routing");
		$display("routing test done");
	endtask

	task automatic report_and_stop();
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// The whole sequence needs well under a thousand cycles.
	initial
	begin
		#20000;
		n_fail++;
		report_and_stop();
	end

	initial
	begin
		n_fail = 0;
		samples_checked = 0;
		sys_rst = 1'b1;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		{setpoint, process_value} = '0;
		{fault_event, trip_mode, fault_clear} = '0;
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		#1;
		t_reset();
		t_deviation();
		t_alarm();
		t_polarity();
		t_routing();
		report_and_stop();
	end
endmodule
